// *** logic/fsp_guard_cell.sv ***
// one sector's persistent and volatile guard bits and its protection decision
// assumes the main block qualifies every strobe; persist bit survives rst_i
`timescale 1ns/1ps
module fsp_guard_cell (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic vol_boot_i,
  input  wire logic pers_prog_i,
  input  wire logic pers_erase_i,
  input  wire logic vol_set_i,
  input  wire logic vol_clear_i,
  output logic      persist_o,
  output logic      volatile_o,
  output logic      protected_o
);
  logic next_persist;
  logic next_volatile;
  logic persist_q = 1'b1;

  always_comb begin
    next_persist  = persist_q;
    next_volatile = volatile_o;
    if (pers_erase_i) begin
      next_persist = 1'b1;
    end else if (pers_prog_i) begin
      next_persist = 1'b0;
    end
    if (vol_set_i) begin
      next_volatile = 1'b0;
    end else if (vol_clear_i) begin
      next_volatile = 1'b1;
    end
  end

  // nonvolatile: not touched by reset
  always_ff @(posedge clk_sys_i) begin
    persist_q <= next_persist;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      volatile_o <= vol_boot_i;
    end else begin
      volatile_o <= next_volatile;
    end
  end

  assign persist_o   = persist_q;
  // volatile bit only matters when persistent bit is erased
  assign protected_o = ~persist_q | ~volatile_o;
endmodule : fsp_guard_cell

// *** logic/fsp_pkg.sv ***
// constants shared by the flash sector protection logic
// assumes a single 100 MHz clock and synchronous active-high reset
package fsp_pkg;
  // --------------------------------------------------------------------------
  // register map (word addresses on the plain register port)
  // --------------------------------------------------------------------------
  localparam logic [7:0]  ADDR_LOCK_WORD   = 8'h00;
  localparam logic [7:0]  ADDR_COMMAND     = 8'h01;
  localparam logic [7:0]  ADDR_STATUS      = 8'h02;
  localparam logic [7:0]  ADDR_SECTOR      = 8'h03;
  localparam logic [7:0]  ADDR_GUARD_READ  = 8'h04;
  localparam logic [7:0]  ADDR_BANK_ACCESS = 8'h05;

  // --------------------------------------------------------------------------
  // lock word fields
  // --------------------------------------------------------------------------
  localparam int LW_SECURE_BIT   = 0;
  localparam int LW_PERSIST_BIT  = 1;
  localparam int LW_PASSWORD_BIT = 2;
  localparam int LW_ERASE_OPT    = 3;
  localparam int LW_VOL_BOOT     = 4;
  localparam logic [4:0]  LOCK_WORD_BLANK = 5'h1F;
  localparam logic [10:0] LOCK_RSVD_ONES  = 11'h7FF;

  // --------------------------------------------------------------------------
  // commands written to ADDR_COMMAND bits [3:0]
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    FSP_CMD_NONE        = 4'h0,
    FSP_CMD_LOCK_ENTER  = 4'h1,
    FSP_CMD_LOCK_PROG   = 4'h2,
    FSP_CMD_PERS_ENTER  = 4'h3,
    FSP_CMD_PERS_PROG   = 4'h4,
    FSP_CMD_PERS_ERASE  = 4'h5,
    FSP_CMD_VOL_SET     = 4'h6,
    FSP_CMD_VOL_CLEAR   = 4'h7,
    FSP_CMD_FREEZE_SET  = 4'h8,
    FSP_CMD_EXIT        = 4'h9,
    FSP_CMD_ARRAY_WRITE = 4'hA
  } fsp_cmd_t;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int NV_PROG_TIME_NS = 1000;
  localparam int NV_PROG_CYCLES  = (NV_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_TIME_NS = 2000;
  localparam int TIMEOUT_CYCLES  = TIMEOUT_TIME_NS / CLK_PERIOD_NS;

  // status bits
  localparam int ST_BUSY    = 0;
  localparam int ST_ABORT   = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_IGNORED = 3;
endpackage : fsp_pkg

// *** logic/fsp_protect.sv ***
// file holds the top of the sector protection logic
// assumes a register master on a plain strobe port, one clock, sync reset
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module fsp_protect #(
  parameter int                     SECTORS       = 16,
  parameter int                     BANKS         = 4,
  parameter logic                   ERASE_ALL_OPT = 1'b1,
  parameter logic                   VOL_BOOT_OPT  = 1'b0,
  parameter int                     SW            = $clog2(SECTORS),
  parameter int                     BW            = $clog2(BANKS)
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        suspended_i,
  output logic [15:0]      rdata_o,
  output logic             array_write_o,
  output logic [SW-1:0]    array_sector_o
);
  // --------------------------------------------------------------------------
  // modes
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FSP_READ, FSP_LOCK_MODE, FSP_LOCK_BUSY, FSP_PERS_MODE, FSP_PERS_BUSY, FSP_VOL_MODE
  } fsp_state_t;

  localparam int TCW = 9;

  fsp_state_t        state;
  fsp_state_t        next_state;
  // factory straps sit in bits 4:3, the scheme and secure bits ship blank
  logic [4:0]        lock_word = {VOL_BOOT_OPT, ERASE_ALL_OPT, 3'h7};
  logic [4:0]        next_lock_word;
  logic [4:0]        lock_pending;
  logic [4:0]        next_lock_pending;
  logic              freeze;
  logic              next_freeze;
  logic [3:0]        status;
  logic [3:0]        next_status;
  logic [SW-1:0]     sector;
  logic [SW-1:0]     next_sector;
  logic              pers_erasing;
  logic              next_pers_erasing;
  logic              vol_op_set;
  logic              next_vol_op_set;
  logic [15:0]       next_rdata;
  logic              next_array_write;
  logic [SW-1:0]     next_array_sector;
  logic              timer_start;
  logic [TCW-1:0]    timer_load;
  logic              timer_done;
  logic [SECTORS-1:0] pers_bits;
  logic [SECTORS-1:0] vol_bits;
  logic [SECTORS-1:0] prot_bits;
  logic [SECTORS-1:0] pers_prog_str;
  logic [SECTORS-1:0] vol_set_str;
  logic [SECTORS-1:0] vol_clr_str;
  logic              pers_erase_str;
  logic              vol_boot_latch;
  logic [BANKS-1:0]  bank_ok;
  logic [BW-1:0]     target_bank;
  logic              cmd_wr;
  fsp_pkg::fsp_cmd_t cmd;
  logic [SW-1:0]     cmd_sector;

  assign cmd_wr      = wr_i && (addr_i == fsp_pkg::ADDR_COMMAND);
  assign cmd         = fsp_pkg::fsp_cmd_t'(wdata_i[3:0]);
  assign cmd_sector  = sector;
  assign target_bank = sector[SW-1 -: BW];

  // --------------------------------------------------------------------------
  // guard bit storage
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SECTORS; g = g + 1) begin : g_cell
      fsp_guard_cell u_cell (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .vol_boot_i   (vol_boot_latch),
        .pers_prog_i  (pers_prog_str[g]),
        .pers_erase_i (pers_erase_str),
        .vol_set_i    (vol_set_str[g]),
        .vol_clear_i  (vol_clr_str[g]),
        .persist_o    (pers_bits[g]),
        .volatile_o   (vol_bits[g]),
        .protected_o  (prot_bits[g])
      );
    end
  endgenerate

  assign vol_boot_latch = lock_word[fsp_pkg::LW_VOL_BOOT];

  fsp_timer #(
    .CW (TCW)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .start_i   (timer_start),
    .load_i    (timer_load),
    .done_o    (timer_done)
  );

  // --------------------------------------------------------------------------
  // bank access map
  // --------------------------------------------------------------------------
  always_comb begin
    bank_ok = '1;
    case (state)
      FSP_LOCK_MODE, FSP_PERS_MODE: bank_ok[0] = 1'b0;
      FSP_LOCK_BUSY: bank_ok = '0;
      FSP_PERS_BUSY: begin
        bank_ok[0] = 1'b0;
        if (!pers_erasing) begin
          bank_ok[target_bank] = 1'b0;
        end
      end
      default: bank_ok = '1;
    endcase
  end

  // --------------------------------------------------------------------------
  // command and mode control
  // --------------------------------------------------------------------------
  always_comb begin
    next_state        = state;
    next_lock_word    = lock_word;
    next_lock_pending = lock_pending;
    next_freeze       = freeze;
    next_status       = status;
    next_sector       = sector;
    next_pers_erasing = pers_erasing;
    next_vol_op_set   = vol_op_set;
    next_array_write  = 1'b0;
    next_array_sector = array_sector_o;
    timer_start       = 1'b0;
    timer_load        = '0;
    pers_prog_str     = '0;
    pers_erase_str    = 1'b0;
    vol_set_str       = '0;
    vol_clr_str       = '0;
    if (wr_i && addr_i == fsp_pkg::ADDR_SECTOR) begin
      next_sector = wdata_i[SW-1:0];
    end
    if (wr_i && addr_i == fsp_pkg::ADDR_STATUS) begin
      next_status = status & ~wdata_i[3:0];
    end
    case (state)
      FSP_READ: begin
        if (cmd_wr) begin
          case (cmd)
            fsp_pkg::FSP_CMD_LOCK_ENTER: begin
              if (!suspended_i) next_state = FSP_LOCK_MODE;
            end
            fsp_pkg::FSP_CMD_PERS_ENTER: begin
              if (!suspended_i) next_state = FSP_PERS_MODE;
            end
            fsp_pkg::FSP_CMD_VOL_SET, fsp_pkg::FSP_CMD_VOL_CLEAR: begin
              // write data moves on after the strobe, so keep the kind of command
              next_vol_op_set = (cmd == fsp_pkg::FSP_CMD_VOL_SET);
              if (!suspended_i) next_state = FSP_VOL_MODE;
            end
            fsp_pkg::FSP_CMD_FREEZE_SET: next_freeze = 1'b0;
            fsp_pkg::FSP_CMD_ARRAY_WRITE: begin
              if (prot_bits[cmd_sector]) begin
                next_status[fsp_pkg::ST_IGNORED] = 1'b1;
              end else begin
                next_array_write  = 1'b1;
                next_array_sector = cmd_sector;
              end
            end
            default: next_state = FSP_READ;
          endcase
        end
      end
      FSP_LOCK_MODE: begin
        if (cmd_wr && cmd == fsp_pkg::FSP_CMD_EXIT) begin
          next_state = FSP_READ;
        end else if (cmd_wr && cmd == fsp_pkg::FSP_CMD_LOCK_PROG) begin
          next_lock_pending = lock_word & wdata_i[8:4];
          // factory bits are not writable here
          next_lock_pending[fsp_pkg::LW_ERASE_OPT] = lock_word[fsp_pkg::LW_ERASE_OPT];
          next_lock_pending[fsp_pkg::LW_VOL_BOOT]  = lock_word[fsp_pkg::LW_VOL_BOOT];
          if (!wdata_i[4 + fsp_pkg::LW_PERSIST_BIT] && !wdata_i[4 + fsp_pkg::LW_PASSWORD_BIT])
          begin
            next_status[fsp_pkg::ST_ABORT] = 1'b1;
          end else if ((!lock_word[fsp_pkg::LW_PERSIST_BIT]
                        && !wdata_i[4 + fsp_pkg::LW_PASSWORD_BIT])
                    || (!lock_word[fsp_pkg::LW_PASSWORD_BIT]
                        && !wdata_i[4 + fsp_pkg::LW_PERSIST_BIT])) begin
            next_status[fsp_pkg::ST_ABORT] = 1'b1;
          end else begin
            next_state                    = FSP_LOCK_BUSY;
            next_status[fsp_pkg::ST_BUSY] = 1'b1;
            timer_start = 1'b1;
            timer_load  = TCW'(fsp_pkg::NV_PROG_CYCLES);
          end
        end
      end
      FSP_LOCK_BUSY: begin
        if (timer_done) begin
          next_lock_word                = lock_pending;
          next_status[fsp_pkg::ST_BUSY] = 1'b0;
          next_state                    = FSP_LOCK_MODE;
        end
      end
      FSP_PERS_MODE: begin
        if (cmd_wr && cmd == fsp_pkg::FSP_CMD_EXIT) begin
          next_state = FSP_READ;
        end else if (cmd_wr && (cmd == fsp_pkg::FSP_CMD_PERS_PROG
                             || cmd == fsp_pkg::FSP_CMD_PERS_ERASE)) begin
          next_pers_erasing             = (cmd == fsp_pkg::FSP_CMD_PERS_ERASE);
          next_state                    = FSP_PERS_BUSY;
          next_status[fsp_pkg::ST_BUSY] = 1'b1;
          timer_start = 1'b1;
          timer_load  = freeze ? TCW'(fsp_pkg::NV_PROG_CYCLES)
                               : TCW'(fsp_pkg::TIMEOUT_CYCLES);
        end
      end
      FSP_PERS_BUSY: begin
        if (timer_done) begin
          next_status[fsp_pkg::ST_BUSY] = 1'b0;
          next_state                    = FSP_PERS_MODE;
          if (!freeze) begin
            next_status[fsp_pkg::ST_TIMEOUT] = 1'b1;
          end else if (pers_erasing) begin
            if (lock_word[fsp_pkg::LW_ERASE_OPT]) begin
              pers_erase_str = 1'b1;
            end else begin
              next_status[fsp_pkg::ST_IGNORED] = 1'b1;
            end
          end else begin
            pers_prog_str[sector] = 1'b1;
          end
        end
      end
      FSP_VOL_MODE: begin
        // one-cycle action: nothing to poll
        next_state = FSP_READ;
        if (pers_bits[sector]) begin
          vol_set_str[sector] = vol_op_set;
          vol_clr_str[sector] = !vol_op_set;
        end
      end
      default: next_state = FSP_READ;
    endcase
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        fsp_pkg::ADDR_LOCK_WORD: next_rdata = {fsp_pkg::LOCK_RSVD_ONES, lock_word};
        fsp_pkg::ADDR_STATUS:    next_rdata = {7'h00, freeze, 3'h0, state == FSP_READ, status};
        fsp_pkg::ADDR_SECTOR:    next_rdata = 16'(sector);
        fsp_pkg::ADDR_GUARD_READ:
          next_rdata = {13'h0000, prot_bits[sector], vol_bits[sector], pers_bits[sector]};
        fsp_pkg::ADDR_BANK_ACCESS: next_rdata = 16'(bank_ok);
        default:                 next_rdata = 16'h0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // lock word is nonvolatile, so reset leaves it alone
  always_ff @(posedge clk_sys_i) begin
    lock_word <= next_lock_word;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state          <= FSP_READ;
      lock_pending   <= fsp_pkg::LOCK_WORD_BLANK;
      freeze         <= 1'b1;
      status         <= 4'h0;
      sector         <= '0;
      pers_erasing   <= 1'b0;
      vol_op_set     <= 1'b0;
      rdata_o        <= 16'h0000;
      array_write_o  <= 1'b0;
      array_sector_o <= '0;
    end else begin
      state          <= next_state;
      lock_pending   <= next_lock_pending;
      freeze         <= next_freeze;
      status         <= next_status;
      sector         <= next_sector;
      pers_erasing   <= next_pers_erasing;
      vol_op_set     <= next_vol_op_set;
      rdata_o        <= next_rdata;
      array_write_o  <= next_array_write;
      array_sector_o <= next_array_sector;
    end
  end

endmodule : fsp_protect

// *** logic/fsp_timer.sv ***
// down counter that flags the end of a nonvolatile program or erase
// assumes start is a one-cycle pulse; restarting reloads the count
`timescale 1ns/1ps
module fsp_timer #(
  parameter int CW = 9
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire logic          start_i,
  input  wire logic [CW-1:0] load_i,
  output logic               done_o
);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (start_i) begin
      next_count = load_i;
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done  = (count == {{(CW-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count  <= '0;
      done_o <= 1'b0;
    end else begin
      count  <= next_count;
      done_o <= next_done;
    end
  end
endmodule : fsp_timer

// *** testbench/fsp_host_model.sv ***
// host model: issues single-cycle register reads and writes on the plain port
// assumes the slave never stalls and read data stand one cycle after the strobe
`timescale 1ns/1ps
module fsp_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] rdata_i,
  output logic [7:0]       addr_o,
  output logic [15:0]      wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end
  // released lines show inverted junk, so a stale address never looks valid
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg
  // reads go to whatever register word a names, the status word or any other, one access at a time
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd_reg
endmodule : fsp_host_model

// *** testbench/fsp_protect_asserts.sv ***
// checker for the sector protection top: read data, lock word, array write pulses
// assumes it is bound to fsp_protect and sees only that module's ports
`timescale 1ns/1ps
module fsp_protect_asserts #(
  parameter logic ERASE_ALL_OPT = 1'b1,
  parameter int   SW            = 4
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire logic [7:0]    addr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  input  wire logic          suspended_i,
  input  wire logic [15:0]   rdata_o,
  input  wire logic          array_write_o,
  input  wire logic [SW-1:0] array_sector_o
);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // command nibble kept apart so that the past value is taken of a plain signal
  logic [3:0] cmd_nib;
  assign cmd_nib = wdata_i[3:0];
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  chk_rsvd_ones: assert property ($past(rd_i) && $past(addr_i) == fsp_pkg::ADDR_LOCK_WORD
    |-> rdata_o[15:5] == fsp_pkg::LOCK_RSVD_ONES) else $error("lock word upper bits not ones");
  chk_mode_excl: assert property ($past(rd_i) && $past(addr_i) == fsp_pkg::ADDR_LOCK_WORD
    |-> rdata_o[2:1] != 2'b00) else $error("both scheme bits programmed");
  chk_erase_opt: assert property ($past(rd_i) && $past(addr_i) == fsp_pkg::ADDR_LOCK_WORD
    |-> rdata_o[3] == ERASE_ALL_OPT) else $error("erase option bit wrong");
  chk_guard_decide: assert property ($past(rd_i) && $past(addr_i) == fsp_pkg::ADDR_GUARD_READ
    |-> rdata_o[2] == !(rdata_o[0] && rdata_o[1])) else $error("protection decision wrong");
  chk_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 8'h05
    |-> rdata_o == 16'h0000) else $error("unmapped read not zero");
  chk_aw_cause: assert property (array_write_o |-> $past(wr_i)
    && $past(addr_i) == fsp_pkg::ADDR_COMMAND && $past(cmd_nib) == 4'hA)
    else $error("array write pulse without array write command");
  chk_aw_pulse: assert property (array_write_o && !wr_i |=> !array_write_o)
    else $error("array write pulse longer than one cycle");
  chk_reset_quiet: assert property ($past(rst_i) |-> rdata_o == 16'h0000 && !array_write_o)
    else $error("outputs not quiet after reset");
endmodule : fsp_protect_asserts

bind fsp_protect fsp_protect_asserts #(
  .ERASE_ALL_OPT(ERASE_ALL_OPT),
  .SW           (SW)
) chk_u (
  .clk_sys_i     (clk_sys_i),
  .rst_i         (rst_i),
  .addr_i        (addr_i),
  .wdata_i       (wdata_i),
  .wr_i          (wr_i),
  .rd_i          (rd_i),
  .suspended_i   (suspended_i),
  .rdata_o       (rdata_o),
  .array_write_o (array_write_o),
  .array_sector_o(array_sector_o)
);

// *** testbench/fsp_protect_tb.sv ***
// self-checking bench for the sector protection top
// assumes fsp_host_model drives the register port and the checker is bound
`timescale 1ns/1ps
module fsp_protect_tb;
  logic        clk_sys_i;
  logic        rst_i;
  logic        suspended_i;
  logic        wr_i;
  logic        rd_i;
  logic        array_write_o;
  logic [7:0]  addr_i;
  logic [15:0] wdata_i;
  logic [15:0] rdata_o;
  logic [15:0] v;
  logic [15:0] n_aw = 16'h0000;
  logic [3:0]  last_sec;
  logic [3:0]  array_sector_o;
  int          n_errors;
  int          n_checks;

  fsp_protect dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .suspended_i(suspended_i),
    .rdata_o(rdata_o), .array_write_o(array_write_o), .array_sector_o(array_sector_o));
  fsp_host_model host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .addr_o(addr_i),
    .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (array_write_o === 1'b1) begin
      n_aw     <= n_aw + 16'h0001;
      last_sec <= array_sector_o;
    end
  end
  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input fsp_pkg::fsp_cmd_t c, input logic [4:0] d);
    host_u.wr_reg(fsp_pkg::ADDR_COMMAND, {7'h00, d, c});
  endtask : cmd
  task automatic rd(input logic [7:0] a);
    host_u.rd_reg(a, v);
  endtask : rd
  task automatic guard(input logic [3:0] s);
    host_u.wr_reg(fsp_pkg::ADDR_SECTOR, {12'h000, s});
    rd(fsp_pkg::ADDR_GUARD_READ);
  endtask : guard
  // polling starts at once, no settling delay
  task automatic wait_idle;
    for (int i = 0; i < 300; i++) begin
      rd(fsp_pkg::ADDR_STATUS);
      if (v[fsp_pkg::ST_BUSY] === 1'b0) return;
    end
    n_errors++;
    $display("mismatch at %0t: busy never cleared", $time);
  endtask : wait_idle
  task automatic aw_try(input logic [3:0] s, input logic [15:0] exp);
    logic [15:0] base;
    guard(s);
    base = n_aw;
    cmd(fsp_pkg::FSP_CMD_ARRAY_WRITE, 5'h00);
    repeat (2) @(posedge clk_sys_i);
    check(n_aw - base, exp);
  endtask : aw_try
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200us;
    n_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    wrap_up();
  end
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    n_errors    = 0;
    n_checks    = 0;
    suspended_i = 1'b0;
    rst_i       = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // factory straps: erase-all enabled, volatile guards boot protected
    rd(fsp_pkg::ADDR_LOCK_WORD);
    check(v | 16'h0010, 16'hFFFF);
    check(v & 16'h0010, 16'h0000);
    suspended_i <= 1'b1;
    cmd(fsp_pkg::FSP_CMD_LOCK_ENTER, 5'h00);
    rd(fsp_pkg::ADDR_BANK_ACCESS);
    check(v & 16'h000F, 16'h000F);
    suspended_i <= 1'b0;
    cmd(fsp_pkg::FSP_CMD_LOCK_ENTER, 5'h00);
    rd(fsp_pkg::ADDR_BANK_ACCESS);
    check(v & 16'h000F, 16'h000E);
    cmd(fsp_pkg::FSP_CMD_LOCK_PROG, 5'h19);
    wait_idle();
    check(v & 16'h0002, 16'h0002);
    rd(fsp_pkg::ADDR_LOCK_WORD);
    check(v | 16'h0010, 16'hFFFF);
    host_u.wr_reg(fsp_pkg::ADDR_STATUS, 16'h000F);
    cmd(fsp_pkg::FSP_CMD_LOCK_PROG, 5'h1D);
    wait_idle();
    rd(fsp_pkg::ADDR_LOCK_WORD);
    check(v | 16'h0010, 16'hFFFD);
    cmd(fsp_pkg::FSP_CMD_LOCK_PROG, 5'h1B);
    wait_idle();
    rd(fsp_pkg::ADDR_LOCK_WORD);
    check(v | 16'h0010, 16'hFFFD);
    cmd(fsp_pkg::FSP_CMD_LOCK_PROG, 5'h1C);
    wait_idle();
    rd(fsp_pkg::ADDR_LOCK_WORD);
    check(v | 16'h0010, 16'hFFFC);
    cmd(fsp_pkg::FSP_CMD_EXIT, 5'h00);
    rd(fsp_pkg::ADDR_STATUS);
    check(v & 16'h0010, 16'h0010);
    cmd(fsp_pkg::FSP_CMD_PERS_ENTER, 5'h00);
    host_u.wr_reg(fsp_pkg::ADDR_SECTOR, 16'h0009);
    cmd(fsp_pkg::FSP_CMD_PERS_PROG, 5'h00);
    rd(fsp_pkg::ADDR_BANK_ACCESS);
    check(v & 16'h000F, 16'h000A);
    wait_idle();
    guard(4'h9);
    check(v & 16'h0007, 16'h0004);
    guard(4'h3);
    check(v & 16'h0001, 16'h0001);
    cmd(fsp_pkg::FSP_CMD_PERS_ERASE, 5'h00);
    wait_idle();
    guard(4'h9);
    check(v & 16'h0001, 16'h0001);
    cmd(fsp_pkg::FSP_CMD_PERS_PROG, 5'h00);
    wait_idle();
    cmd(fsp_pkg::FSP_CMD_EXIT, 5'h00);
    cmd(fsp_pkg::FSP_CMD_VOL_CLEAR, 5'h00);
    guard(4'h9);
    check(v & 16'h0007, 16'h0004);
    host_u.wr_reg(fsp_pkg::ADDR_SECTOR, 16'h0005);
    cmd(fsp_pkg::FSP_CMD_VOL_CLEAR, 5'h00);
    rd(fsp_pkg::ADDR_STATUS);
    check(v & 16'h0001, 16'h0000);
    guard(4'h5);
    check(v & 16'h0007, 16'h0003);
    aw_try(4'h5, 16'h0001);
    check({12'h000, last_sec}, 16'h0005);
    aw_try(4'h9, 16'h0000);
    aw_try(4'h0, 16'h0000);
    rd(fsp_pkg::ADDR_STATUS);
    check(v & 16'h0008, 16'h0008);
    host_u.wr_reg(fsp_pkg::ADDR_SECTOR, 16'h0005);
    cmd(fsp_pkg::FSP_CMD_VOL_SET, 5'h00);
    aw_try(4'h5, 16'h0000);
    check(v & 16'h0007, 16'h0005);
    cmd(fsp_pkg::FSP_CMD_FREEZE_SET, 5'h00);
    cmd(fsp_pkg::FSP_CMD_PERS_ENTER, 5'h00);
    rd(fsp_pkg::ADDR_STATUS);
    check(v & 16'h0100, 16'h0000);
    host_u.wr_reg(fsp_pkg::ADDR_SECTOR, 16'h0005);
    cmd(fsp_pkg::FSP_CMD_PERS_PROG, 5'h00);
    wait_idle();
    check(v & 16'h0004, 16'h0004);
    guard(4'h5);
    check(v & 16'h0001, 16'h0001);
    cmd(fsp_pkg::FSP_CMD_EXIT, 5'h00);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(fsp_pkg::ADDR_STATUS);
    check(v & 16'h0110, 16'h0110);
    rd(fsp_pkg::ADDR_LOCK_WORD);
    check(v | 16'h0010, 16'hFFFC);
    guard(4'h9);
    check(v & 16'h0007, 16'h0004);
    guard(4'h5);
    check(v & 16'h0007, 16'h0005);
    wrap_up();
  end
endmodule : fsp_protect_tb
